// ---- logic/cis_chan_or.sv ----
// Pending summary of one channel: OR of its enabled interrupt sources
`timescale 1ns/1ps

module cis_chan_or #(
  parameter int NSRC = 8
) (
  input  wire logic [NSRC-1:0] src_pending,
  input  wire logic [NSRC-1:0] src_enable,
  output logic                 per_channel_pending_bit
);

  // Evaluated continuously so the summary follows the sources without a read
  assign per_channel_pending_bit = |(src_pending & src_enable);

endmodule

// ---- logic/cis_defs.svh ----
// Register offsets, field positions and reset values for the channel irq summary block
`ifndef CIS_DEFS_SVH
`define CIS_DEFS_SVH

// ==========================================================================
// Register byte offsets
`define CIS_LOWER_SUMMARY_OFS   12'h2c0
`define CIS_UPPER_SUMMARY_OFS   12'h300
`define CIS_ZERO_SUMMARY_OFS    12'h380
`define CIS_TIMER_STATUS_OFS    12'h3c0
`define CIS_EXPIRY_MASK_OFS     12'h3c4

// ==========================================================================
// Field positions
`define CIS_UPPER_MSB           6
`define CIS_ZERO_BIT            7
`define CIS_EXPIRY_FLAG_BIT     0
`define CIS_EXPIRY_MASK_BIT     0

// ==========================================================================
// Reset values
`define CIS_SUMMARY_RST         8'h00
`define CIS_TIMER_STATUS_RST    1'h0
`define CIS_EXPIRY_MASK_RST     1'h0

`endif

// ---- logic/cis_pkg.sv ----
// Types shared by the channel irq summary block
package cis_pkg;

  // ==========================================================================
  // Register select decoded from the bus address
  typedef enum logic [2:0] {
    CIS_SEL_LOWER,
    CIS_SEL_UPPER,
    CIS_SEL_ZERO,
    CIS_SEL_TIMER,
    CIS_SEL_MASK,
    CIS_SEL_NONE
  } cis_sel_e;

  typedef logic [7:0] cis_byte_t;

endpackage

// ---- logic/cis_top.sv ----
// APB register block: channel interrupt summaries and one-second expiry flag
// ==========================================================================
// Functional notes
// - Upper summary bits 6..0 show pending interrupts of channels 15..9.
// - A summary bit is 0 with nothing pending, and after reset.
// - Channel zero summary bit 7 shows channel 0 pending; other bits reserved.
// - Summary registers are read-only, reset to zero, not cleared by reading.
// - Expiry flag is meaningful only while the expiry mask bit is 0.
// - Timer expiry sets expiry flag bit 0 and, while the expiry mask bit is 0, raises the interrupt output.
// - Writing 1 to the expiry flag clears it to 0.
// - Timer status register at 0x3c0, read/write, reset 0x00, bits 7..1 reserved.
// - Lower summary at 0x2c0 carries channels 8..1 in bits 7..0.
`timescale 1ns/1ps
`include "cis_defs.svh"

module cis_top #(
  parameter int NCH  = 16,
  parameter int NSRC = 8
) (
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [NCH*NSRC-1:0]  src_pending,
  input  wire logic [NCH*NSRC-1:0]  src_enable,
  input  wire logic                 second_tick,
  output logic                      irq_out
);

  // ==========================================================================
  // Declarations
  logic             [NCH-1:0] next_sum;
  logic             [NCH-1:0] sum_q;
  logic                       second_expiry_flag;
  logic                       second_expiry_mask;
  cis_pkg::cis_sel_e          sel;
  cis_pkg::cis_byte_t         read_byte;
  logic                       setup_rd;
  logic                       access;
  logic                       wr_timer;
  logic                       wr_mask;
  logic                       clear_flag;

  // ==========================================================================
  // Per-channel pending OR
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : g_chan
      cis_chan_or #(
        .NSRC (NSRC)
      ) u_or (
        .src_pending             (src_pending[ch*NSRC +: NSRC]),
        .src_enable              (src_enable[ch*NSRC +: NSRC]),
        .per_channel_pending_bit (next_sum[ch])
      );
    end
  endgenerate

  // Summary is sampled so it has a clean reset value; reads never touch it
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sum_q <= '0;
    end else begin
      sum_q <= next_sum;
    end
  end

  // ==========================================================================
  // Bus decode
  always_comb begin
    unique case (paddr)
      `CIS_LOWER_SUMMARY_OFS: sel = cis_pkg::CIS_SEL_LOWER;
      `CIS_UPPER_SUMMARY_OFS: sel = cis_pkg::CIS_SEL_UPPER;
      `CIS_ZERO_SUMMARY_OFS:  sel = cis_pkg::CIS_SEL_ZERO;
      `CIS_TIMER_STATUS_OFS:  sel = cis_pkg::CIS_SEL_TIMER;
      `CIS_EXPIRY_MASK_OFS:   sel = cis_pkg::CIS_SEL_MASK;
      default:                sel = cis_pkg::CIS_SEL_NONE;
    endcase
  end

  assign access     = psel && penable;
  assign setup_rd   = psel && !penable && !pwrite;
  assign wr_timer   = access && pwrite && pstrb[0] && (sel == cis_pkg::CIS_SEL_TIMER);
  assign wr_mask    = access && pwrite && pstrb[0] && (sel == cis_pkg::CIS_SEL_MASK);
  assign clear_flag = wr_timer && pwdata[`CIS_EXPIRY_FLAG_BIT];

  // Zero wait states; unmapped offsets answer with an error
  assign pready  = 1'b1;
  assign pslverr = access && (sel == cis_pkg::CIS_SEL_NONE);

  // Read mux; reserved bits read as zero
  always_comb begin
    read_byte = `CIS_SUMMARY_RST;
    unique case (sel)
      cis_pkg::CIS_SEL_LOWER: begin
        read_byte = sum_q[8:1];
      end
      cis_pkg::CIS_SEL_UPPER: begin
        read_byte = {1'b0, sum_q[15:9]};
      end
      cis_pkg::CIS_SEL_ZERO: begin
        read_byte[`CIS_ZERO_BIT] = sum_q[0];
      end
      cis_pkg::CIS_SEL_TIMER: begin
        read_byte[`CIS_EXPIRY_FLAG_BIT] = second_expiry_flag;
      end
      cis_pkg::CIS_SEL_MASK: begin
        read_byte[`CIS_EXPIRY_MASK_BIT] = second_expiry_mask;
      end
      cis_pkg::CIS_SEL_NONE: begin
        read_byte = `CIS_SUMMARY_RST;
      end
    endcase
  end

  // Read data captured in the setup cycle so it is a flop in the access cycle
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata <= {24'h00_0000, read_byte};
    end
  end

  // ==========================================================================
  // One-second expiry flag and mask
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      second_expiry_mask <= `CIS_EXPIRY_MASK_RST;
    end else if (wr_mask) begin
      second_expiry_mask <= pwdata[`CIS_EXPIRY_MASK_BIT];
    end
  end

  // A tick in the same cycle as a clear wins, so no expiry is lost
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      second_expiry_flag <= `CIS_TIMER_STATUS_RST;
    end else if (second_tick) begin
      second_expiry_flag <= 1'b1;
    end else if (clear_flag) begin
      second_expiry_flag <= 1'b0;
    end
  end

  // Flag still records while masked, but it is not trusted nor signalled then
  assign irq_out = second_expiry_flag && !second_expiry_mask;

  // ==========================================================================
  // Assertions
  sequence s_setup_read(logic [11:0] ofs);
    psel && !penable && !pwrite && (paddr == ofs);
  endsequence

  sequence s_access_write(logic [11:0] ofs);
    psel && penable && pwrite && pstrb[0] && (paddr == ofs);
  endsequence

  // Clear request on its own, and the same request racing a timer expiry
  sequence s_clear_alone;
    s_access_write(`CIS_TIMER_STATUS_OFS) ##0 (pwdata[`CIS_EXPIRY_FLAG_BIT] && !second_tick);
  endsequence

  sequence s_clear_race;
    s_access_write(`CIS_TIMER_STATUS_OFS) ##0 (pwdata[`CIS_EXPIRY_FLAG_BIT] && second_tick);
  endsequence

  // Any address that decodes to no register
  sequence s_unmapped_addr;
    (paddr != `CIS_LOWER_SUMMARY_OFS) && (paddr != `CIS_UPPER_SUMMARY_OFS) &&
    (paddr != `CIS_ZERO_SUMMARY_OFS) && (paddr != `CIS_TIMER_STATUS_OFS) &&
    (paddr != `CIS_EXPIRY_MASK_OFS);
  endsequence

  property p_upper_read;
    @(posedge mclk) disable iff (!rst_b)
      s_setup_read(`CIS_UPPER_SUMMARY_OFS) |=>
        (prdata[6:0] == $past(sum_q[15:9])) && (prdata[31:7] == 25'h0);
  endproperty
  a_upper_read: assert property (p_upper_read)
    else $error("upper summary read data wrong");

  property p_idle_zero;
    @(posedge mclk) disable iff (!rst_b)
      ((src_pending & src_enable) == '0) |=> (sum_q == '0);
  endproperty
  a_idle_zero: assert property (p_idle_zero)
    else $error("summary set with nothing pending");

  property p_zero_read;
    @(posedge mclk) disable iff (!rst_b)
      s_setup_read(`CIS_ZERO_SUMMARY_OFS) |=>
        (prdata[7] == $past(sum_q[0])) && (prdata[6:0] == 7'h00);
  endproperty
  a_zero_read: assert property (p_zero_read)
    else $error("channel zero summary read data wrong");

  property p_reset_zero;
    @(posedge mclk) !rst_b |=> (sum_q == '0) && !second_expiry_flag && !irq_out;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("state not cleared by reset");

  property p_read_keeps;
    @(posedge mclk) disable iff (!rst_b)
      (psel && penable && (paddr == `CIS_UPPER_SUMMARY_OFS) && next_sum[9]) ##1
        next_sum[9] |=> sum_q[9];
  endproperty
  a_read_keeps: assert property (p_read_keeps)
    else $error("summary bit dropped around a read");

  property p_masked_quiet;
    @(posedge mclk) disable iff (!rst_b)
      second_expiry_mask |-> !irq_out;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("interrupt raised while expiry masked");

  property p_tick_sets;
    @(posedge mclk) disable iff (!rst_b)
      second_tick |=> second_expiry_flag && (irq_out == !second_expiry_mask);
  endproperty
  a_tick_sets: assert property (p_tick_sets)
    else $error("expiry tick did not set flag or interrupt");

  property p_clear;
    @(posedge mclk) disable iff (!rst_b)
      s_clear_alone |=>
        !second_expiry_flag ##1 (!second_expiry_flag || $past(second_tick));
  endproperty
  a_clear: assert property (p_clear)
    else $error("write one did not clear expiry flag");

  property p_set_wins;
    @(posedge mclk) disable iff (!rst_b)
      s_clear_race |=>
        second_expiry_flag;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("expiry lost when cleared in same cycle");

  property p_timer_read;
    @(posedge mclk) disable iff (!rst_b)
      s_setup_read(`CIS_TIMER_STATUS_OFS) |=>
        (prdata == {31'h0, $past(second_expiry_flag)}) && !pslverr;
  endproperty
  a_timer_read: assert property (p_timer_read)
    else $error("timer status read data wrong");

  property p_lower_read;
    @(posedge mclk) disable iff (!rst_b)
      s_setup_read(`CIS_LOWER_SUMMARY_OFS) |=>
        (prdata == {24'h00_0000, $past(sum_q[8:1])});
  endproperty
  a_lower_read: assert property (p_lower_read)
    else $error("lower summary read data wrong");

  property p_chan_or;
    @(posedge mclk) disable iff (!rst_b)
      (src_pending[NSRC+1] && src_enable[NSRC+1]) |=> sum_q[1];
  endproperty
  a_chan_or: assert property (p_chan_or)
    else $error("enabled pending source not summarised");

  // ==========================================================================
  // Expiry flag, mask and interrupt
  property p_mask_write;
    @(posedge mclk) disable iff (!rst_b)
      s_access_write(`CIS_EXPIRY_MASK_OFS) |=>
        (second_expiry_mask == $past(pwdata[`CIS_EXPIRY_MASK_BIT]));
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("expiry mask write did not land");

  // Only a written one may take the flag down; a zero in bit 0 leaves it alone
  property p_flag_sticky;
    @(posedge mclk) disable iff (!rst_b)
      (second_expiry_flag && !(psel && penable && pwrite && pstrb[0] &&
        (paddr == `CIS_TIMER_STATUS_OFS) && pwdata[`CIS_EXPIRY_FLAG_BIT])) |=>
        second_expiry_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("expiry flag fell without a clearing write");

  property p_flag_quiet;
    @(posedge mclk) disable iff (!rst_b)
      (!second_expiry_flag && !second_tick) |=> !second_expiry_flag;
  endproperty
  a_flag_quiet: assert property (p_flag_quiet)
    else $error("expiry flag rose without a timer expiry");

  property p_irq_unmasked;
    @(posedge mclk) disable iff (!rst_b)
      (second_expiry_flag && !second_expiry_mask) |-> irq_out;
  endproperty
  a_irq_unmasked: assert property (p_irq_unmasked)
    else $error("unmasked expiry not signalled");

  property p_irq_needs_flag;
    @(posedge mclk) disable iff (!rst_b)
      !second_expiry_flag |-> !irq_out;
  endproperty
  a_irq_needs_flag: assert property (p_irq_needs_flag)
    else $error("interrupt raised with no expiry pending");

  // ==========================================================================
  // Bus protocol checks
  // A summary write is dropped quietly: no error, and the summary keeps tracking sources
  property p_summary_ro;
    @(posedge mclk) disable iff (!rst_b)
      s_access_write(`CIS_UPPER_SUMMARY_OFS) |->
        !pslverr ##1 (sum_q == $past(next_sum));
  endproperty
  a_summary_ro: assert property (p_summary_ro)
    else $error("write to a summary register took effect");

  property p_unmapped_err;
    @(posedge mclk) disable iff (!rst_b)
      (psel && penable) ##0 s_unmapped_addr |-> pslverr;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err)
    else $error("unmapped access gave no error");

  property p_unmapped_zero;
    @(posedge mclk) disable iff (!rst_b)
      (psel && !penable && !pwrite) ##0 s_unmapped_addr |=> (prdata == 32'h0000_0000);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read returned data");

  // Zero wait states: the slave never stretches a transfer
  property p_ready_high;
    @(posedge mclk) disable iff (!rst_b)
      psel |-> pready;
  endproperty
  a_ready_high: assert property (p_ready_high)
    else $error("ready low during a transfer");

  // Read data is a register: it moves only after a setup-phase read
  property p_prdata_holds;
    @(posedge mclk) disable iff (!rst_b)
      (rst_b && !(psel && !penable && !pwrite)) |=> $stable(prdata);
  endproperty
  a_prdata_holds: assert property (p_prdata_holds)
    else $error("read data changed outside a read");

endmodule

// ---- tb/cis_tick_model.sv ----
// One-second timer model: turns a request level into a one-cycle expiry pulse
`timescale 1ns/1ps

module cis_tick_model (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic fire,
  output logic      second_tick
);
  logic fire_q;

  // =========================================================================
  // Edge detect so a long request still gives a single expiry
  always @(posedge mclk) begin
    if (!rst_b) begin
      fire_q <= 1'b0;
      second_tick <= 1'b0;
    end else begin
      fire_q <= fire;
      second_tick <= fire & ~fire_q;
    end
  end
endmodule

// ---- tb/tb_cis_top.sv ----
// Testbench for the channel irq summary register block
`timescale 1ns/1ps
`include "cis_defs.svh"

module tb_cis_top;
  logic         mclk, rst_b, psel, penable, pwrite, fire, err;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic [3:0]   pstrb;
  logic         pready, pslverr, second_tick, irq_out;
  logic [127:0] src_pending, src_enable;
  int           num_errors = 0;
  int           num_checks = 0;
  int           cycles = 0;

  cis_top #(.NCH(16), .NSRC(8)) i_cis_top (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_pending(src_pending), .src_enable(src_enable),
    .second_tick(second_tick), .irq_out(irq_out));

  cis_tick_model i_cis_tick_model (
    .mclk(mclk), .rst_b(rst_b), .fire(fire), .second_tick(second_tick));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // =========================================================================
  // Tasks
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Extra idle edge at the end keeps two calls from driving psel in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  task automatic tick();
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      close_out();
    end
  end

  // =========================================================================
  // Main sequence
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    fire = 1'b0;
    src_pending = '0;
    src_enable = '0;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rchk(`CIS_LOWER_SUMMARY_OFS, 32'h0, "lower");
    rchk(`CIS_UPPER_SUMMARY_OFS, 32'h0, "upper");
    rchk(`CIS_ZERO_SUMMARY_OFS, 32'h0, "zero");
    rchk(`CIS_TIMER_STATUS_OFS, 32'h0, "timer");
    // Source c*8 is pending but disabled, so only bit c*8+1 may set the channel
    for (int c = 0; c < 16; c++) begin
      src_pending <= 128'h3 << (c * 8);
      src_enable <= ~(128'h1 << (c * 8));
      repeat (2) @(posedge mclk);
      rchk(`CIS_LOWER_SUMMARY_OFS, (c >= 1 && c <= 8) ? 32'h1 << (c - 1) : 0, "lower");
      rchk(`CIS_UPPER_SUMMARY_OFS, (c >= 9) ? 32'h1 << (c - 9) : 0, "upper");
      rchk(`CIS_UPPER_SUMMARY_OFS, (c >= 9) ? 32'h1 << (c - 9) : 0, "upper");
      rchk(`CIS_ZERO_SUMMARY_OFS, (c == 0) ? 32'h80 : 0, "zero");
    end
    src_enable <= {16{8'hfe}};
    src_pending <= {16{8'h01}};
    repeat (2) @(posedge mclk);
    apb(1'b1, `CIS_UPPER_SUMMARY_OFS, 32'hff);
    rchk(`CIS_UPPER_SUMMARY_OFS, 32'h0, "upper");
    rchk(`CIS_LOWER_SUMMARY_OFS, 32'h0, "lower");
    tick();
    chk("irq_out", 32'h1, {31'h0, irq_out});
    apb(1'b1, `CIS_TIMER_STATUS_OFS, 32'hfe);
    rchk(`CIS_TIMER_STATUS_OFS, 32'h1, "timer");
    apb(1'b1, `CIS_TIMER_STATUS_OFS, 32'h1);
    rchk(`CIS_TIMER_STATUS_OFS, 32'h0, "timer");
    chk("irq_out", 32'h0, {31'h0, irq_out});
    apb(1'b1, `CIS_EXPIRY_MASK_OFS, 32'h1);
    tick();
    chk("irq_out", 32'h0, {31'h0, irq_out});
    apb(1'b1, `CIS_EXPIRY_MASK_OFS, 32'h0);
    chk("irq_out", 32'h1, {31'h0, irq_out});
    apb(1'b1, `CIS_TIMER_STATUS_OFS, 32'h1);
    chk("irq_out", 32'h0, {31'h0, irq_out});
    // Expiry landing on the clearing write must survive it
    fire <= 1'b1;
    apb(1'b1, `CIS_TIMER_STATUS_OFS, 32'h1);
    fire <= 1'b0;
    rchk(`CIS_TIMER_STATUS_OFS, 32'h1, "timer");
    chk("irq_out", 32'h1, {31'h0, irq_out});
    pstrb <= 4'he;
    apb(1'b1, `CIS_TIMER_STATUS_OFS, 32'h1);
    pstrb <= 4'hf;
    rchk(`CIS_TIMER_STATUS_OFS, 32'h1, "timer");
    apb(1'b1, `CIS_EXPIRY_MASK_OFS, 32'h1);
    // Reset in mid-run must drop the pending flag and the mask
    rst_b <= 1'b0;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rchk(`CIS_TIMER_STATUS_OFS, 32'h0, "timer");
    rchk(`CIS_EXPIRY_MASK_OFS, 32'h0, "mask");
    chk("irq_out", 32'h0, {31'h0, irq_out});
    tick();
    chk("irq_out", 32'h1, {31'h0, irq_out});
    apb(1'b1, `CIS_TIMER_STATUS_OFS, 32'h1);
    chk("irq_out", 32'h0, {31'h0, irq_out});
    apb(1'b0, 12'h004, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    chk("unmapped", 32'h0, rd);
    close_out();
  end
endmodule
